// *** include/spdh_regs.svh ***
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPDH_REGS_SVH
`define SPDH_REGS_SVH

`define SPDH_CTRL_OFF       12'h000
`define SPDH_STAT_OFF       12'h004
`define SPDH_TXDATA_OFF     12'h008
`define SPDH_RXDATA_OFF     12'h00C
`define SPDH_CMD_OFF        12'h010

// control register fields
`define SPDH_CTRL_EN_BIT    0
`define SPDH_CTRL_BAUD_LSB  1
`define SPDH_CTRL_PAR_LSB   4
`define SPDH_CTRL_RESET     32'h0000_0000

// command register: write one to pulse
`define SPDH_CMD_RESP_END   0
`define SPDH_CMD_MODE_LSB   1
`define SPDH_CMD_MODE_GO    3

// status bits
`define SPDH_ST_RXV         0
`define SPDH_ST_RXFULL      1
`define SPDH_ST_TXBUSY      2
`define SPDH_ST_HOLDOFF     3
`define SPDH_ST_SUSP        4
`define SPDH_ST_RESP        5
`define SPDH_ST_ABORT       6
`define SPDH_ST_PERR        7
`define SPDH_ST_MODE_LSB    8
`define SPDH_ST_FRERR       10

// frame and buffer figures
`define SPDH_FRAME_BITS     4'd11
`define SPDH_RXBUF_DEPTH    100
`define SPDH_RXCNT_W        7
`define SPDH_CHAR_CR        8'h0D
`define SPDH_CHAR_LF        8'h0A
`define SPDH_CHAR_ETX       8'h03

// clock and bit periods
`define SPDH_CLK_HZ         20000000
`define SPDH_DIV_W          17

`endif

// *** include/spdh_pkg.sv ***
// types shared by the serial port design files
package spdh_pkg;
	typedef enum logic [2:0] {
		SPDH_B300,
		SPDH_B600,
		SPDH_B1200,
		SPDH_B2400,
		SPDH_B4800,
		SPDH_B9600
	} spdh_baud_t;

	typedef enum logic [1:0] {
		SPDH_PAR_NONE,
		SPDH_PAR_EVEN,
		SPDH_PAR_ODD
	} spdh_par_t;

	typedef enum logic [1:0] {
		SPDH_LOCAL,
		SPDH_REMOTE,
		SPDH_LOCKOUT
	} spdh_mode_t;
endpackage

// *** hw/spdh_rx.sv ***
// receive half of the serial port: start detect, mid-bit sampling, frame check up to the first stop bit
`timescale 1ns/1ps
`include "spdh_regs.svh"
module spdh_rx (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    enable,
	input  wire logic [`SPDH_DIV_W-1:0]  bit_div,
	input  wire logic                    par_on,
	input  wire logic                    par_odd,
	input  wire logic                    rxd,
	output logic                         rx_valid,
	output logic [7:0]                   rx_data,
	output logic                         rx_perr,
	output logic                         rx_ferr
);
	logic [`SPDH_DIV_W-1:0] cnt_q;
	logic [3:0]             bit_q;
	logic [9:0]             sh_q;
	logic                   busy_q;
	logic                   rxd_s1_q;
	logic                   rxd_s2_q;
	wire                    tick = (cnt_q == '0);

	// rxd comes from a cable, so it is synchronised before any decision looks at it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end else begin
			rxd_s1_q <= rxd;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= '0;
			bit_q    <= 4'h0;
			sh_q     <= 10'h000;
			busy_q   <= 1'b0;
			rx_valid <= 1'b0;
			rx_data  <= 8'h00;
			rx_perr  <= 1'b0;
			rx_ferr  <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!busy_q) begin
				if (enable && !rxd_s2_q) begin
					busy_q <= 1'b1;
					bit_q  <= 4'h0;
					cnt_q  <= bit_div >> 1;
				end
			end else if (!tick) begin
				cnt_q <= cnt_q - 1'b1;
			end else begin
				cnt_q <= bit_div;
				bit_q <= bit_q + 4'h1;
				sh_q  <= {rxd_s2_q, sh_q[9:1]};
				if (bit_q == 4'h0 && rxd_s2_q) begin
					busy_q <= 1'b0;
				end
				// lsb first; the second stop bit is not waited for, it overlaps the next start hunt
				if (bit_q == 4'h9) begin // [R1] [R21]
					busy_q   <= 1'b0;
					rx_valid <= 1'b1;
					rx_data  <= par_on ? {1'b0, sh_q[8:2]} : sh_q[9:2]; // [R2]
					rx_perr  <= par_on & ((^sh_q[9:2]) ^ par_odd);
					rx_ferr  <= ~rxd_s2_q;
				end
			end
		end
	end
endmodule

// *** hw/spdh_serial_port.sv ***
// serial programming port with holdoff and ready handshake, apb register file
//
// What the document asks of this block and its host
// R1: frames are eleven bits long
// R2: seven bits plus parity, or eight bits
// R3: six selectable baud rates, 300 to 9600
// R4: always one start, two stop bits
// R5: serial selection disables the parallel bus
// R6: holdoff true while input can be accepted
// R7: host stops within ten characters of holdoff
// R8: holdoff false while receive buffer is full
// R9: holdoff false while query response pending
// R10: host ends commands with newline, reads responses
// R11: sample host ready before each character
// R12: holdoff stays false while output suspended
// R13: control-C aborts and discards pending output
// R14: host drops ready before sending control-C
// R15: hosts without handshake tie ready true
// R16: responses end with carriage return, newline
// R17: mode commands accepted only over serial
// R18: local mode enables all panel keys
// R19: remote keeps local key; lockout disables all
// R20: host selects remote before serial traffic
// R21: lsb first, low start, high stops
`timescale 1ns/1ps
`include "spdh_regs.svh"
module spdh_serial_port (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             txd,
	output logic             holdoff,
	input  wire logic        host_ready,
	output logic             parallel_bus_en,
	output logic             panel_keys_en,
	output logic             local_key_en,
	output logic             device_clear
);
	// configuration
	logic                    en_q;
	spdh_pkg::spdh_baud_t    baud_q;
	spdh_pkg::spdh_par_t     par_q;
	spdh_pkg::spdh_mode_t    mode_q;

	// receive buffer
	logic [7:0]                 rxbuf [0:`SPDH_RXBUF_DEPTH-1];
	logic [`SPDH_RXCNT_W-1:0]   wr_q;
	logic [`SPDH_RXCNT_W-1:0]   rd_q;
	logic [`SPDH_RXCNT_W-1:0]   cnt_q;

	// transmit side, ready synchroniser and sticky receive error flags
	logic [7:0]              txhold_q;
	logic                    txhold_v_q;
	logic [1:0]              term_q;
	logic                    resp_q;
	logic                    tx_busy_q;
	logic [10:0]             tx_sh_q;
	logic [3:0]              tx_bit_q;
	logic [`SPDH_DIV_W-1:0]  tx_cnt_q;
	logic                    susp_q;
	logic                    abort_q;
	logic                    perr_q;
	logic                    ferr_q;
	logic                    rdy_s1_q;
	logic                    rdy_s2_q;

	logic                    rx_valid;
	logic [7:0]              rx_data;
	logic                    rx_perr;
	logic                    rx_ferr;

	function automatic logic [`SPDH_DIV_W-1:0] baud_div(input spdh_pkg::spdh_baud_t b);
		case (b)
			spdh_pkg::SPDH_B300:  baud_div = `SPDH_DIV_W'(`SPDH_CLK_HZ / 300 - 1);
			spdh_pkg::SPDH_B600:  baud_div = `SPDH_DIV_W'(`SPDH_CLK_HZ / 600 - 1);
			spdh_pkg::SPDH_B1200: baud_div = `SPDH_DIV_W'(`SPDH_CLK_HZ / 1200 - 1);
			spdh_pkg::SPDH_B2400: baud_div = `SPDH_DIV_W'(`SPDH_CLK_HZ / 2400 - 1);
			spdh_pkg::SPDH_B4800: baud_div = `SPDH_DIV_W'(`SPDH_CLK_HZ / 4800 - 1);
			default:              baud_div = `SPDH_DIV_W'(`SPDH_CLK_HZ / 9600 - 1);
		endcase
	endfunction

	function automatic logic [`SPDH_RXCNT_W-1:0] ptr_inc(input logic [`SPDH_RXCNT_W-1:0] p);
		ptr_inc = (p == `SPDH_RXCNT_W'(`SPDH_RXBUF_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	wire [`SPDH_DIV_W-1:0] bit_div = baud_div(baud_q); // [R3]
	wire par_on  = (par_q != spdh_pkg::SPDH_PAR_NONE);
	wire par_odd = (par_q == spdh_pkg::SPDH_PAR_ODD);

	// apb decode; zero wait states
	wire acc       = psel & penable;
	wire wr_acc    = acc & pwrite;
	wire rd_acc    = acc & ~pwrite;
	wire hit_ctrl  = (paddr == `SPDH_CTRL_OFF);
	wire hit_stat  = (paddr == `SPDH_STAT_OFF);
	wire hit_tx    = (paddr == `SPDH_TXDATA_OFF);
	wire hit_rx    = (paddr == `SPDH_RXDATA_OFF);
	wire hit_cmd   = (paddr == `SPDH_CMD_OFF);
	wire hit_any   = hit_ctrl | hit_stat | hit_tx | hit_rx | hit_cmd;
	wire wr_ctrl   = wr_acc & hit_ctrl;
	wire wr_tx     = wr_acc & hit_tx & ~txhold_v_q & ~abort_q;
	wire wr_cmd    = wr_acc & hit_cmd;
	wire rd_rx     = rd_acc & hit_rx & (cnt_q != '0);
	wire resp_end  = wr_cmd & pwdata[`SPDH_CMD_RESP_END];
	wire mode_go   = wr_cmd & pwdata[`SPDH_CMD_MODE_GO];
	wire [1:0] mode_sel = pwdata[`SPDH_CMD_MODE_LSB +: 2];
	// status access side effects and the mode strobe
	wire stat_rd   = rd_acc & hit_stat;
	wire abort_clr = wr_acc & hit_stat & pwdata[`SPDH_ST_ABORT];
	wire mode_ok   = mode_go & en_q & (mode_sel != 2'd3);

	// control-C acts on arrival; it is not stored in the buffer
	wire ctrl_c    = rx_valid & (rx_data == `SPDH_CHAR_ETX); // [R13]
	wire rx_push   = rx_valid & ~ctrl_c & (cnt_q != `SPDH_RXCNT_W'(`SPDH_RXBUF_DEPTH));
	wire rx_full   = (cnt_q == `SPDH_RXCNT_W'(`SPDH_RXBUF_DEPTH));

	wire tx_tick   = (tx_cnt_q == '0);
	// the held byte goes before the terminator, so a late end of response cannot overtake it
	wire [7:0] tx_char = txhold_v_q       ? txhold_q :
	                     (term_q == 2'd2) ? `SPDH_CHAR_CR : `SPDH_CHAR_LF;
	wire tx_have   = txhold_v_q | (term_q != 2'd0);
	wire tx_par    = par_odd ? ~(^tx_char[6:0]) : (^tx_char[6:0]);
	wire [7:0] tx_payload = par_on ? {tx_par, tx_char[6:0]} : tx_char; // [R2]
	wire tx_start  = en_q & ~tx_busy_q & tx_have & rdy_s2_q & ~abort_q; // [R11]
	// strobes consumed by a transmitter start, plus the end-of-frame and end-of-response conditions
	wire tx_take_hold = tx_start & txhold_v_q;
	wire tx_take_term = tx_start & ~txhold_v_q & (term_q != 2'd0);
	wire tx_last      = tx_tick & (tx_bit_q == `SPDH_FRAME_BITS - 4'h1); // [R1]
	wire resp_done    = (term_q == 2'd0) & ~txhold_v_q & ~tx_busy_q & ~resp_end;

	spdh_rx u_rx (
		.pclk     (pclk),
		.presetn  (presetn),
		.enable   (en_q),
		.bit_div  (bit_div),
		.par_on   (par_on),
		.par_odd  (par_odd),
		.rxd      (rxd),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_perr  (rx_perr),
		.rx_ferr  (rx_ferr)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_s1_q <= 1'b0;
			rdy_s2_q <= 1'b0;
		end else begin
			rdy_s1_q <= host_ready;
			rdy_s2_q <= rdy_s1_q;
		end
	end

	// configuration; out-of-range codes fall back to a legal setting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q   <= 1'b0;
			baud_q <= spdh_pkg::SPDH_B300;
			par_q  <= spdh_pkg::SPDH_PAR_NONE;
		end else if (wr_ctrl) begin
			en_q   <= pwdata[`SPDH_CTRL_EN_BIT];
			baud_q <= (pwdata[`SPDH_CTRL_BAUD_LSB +: 3] > 3'd5) ? spdh_pkg::SPDH_B9600
			        : spdh_pkg::spdh_baud_t'(pwdata[`SPDH_CTRL_BAUD_LSB +: 3]);
			par_q  <= (pwdata[`SPDH_CTRL_PAR_LSB +: 2] == 2'd3) ? spdh_pkg::SPDH_PAR_NONE
			        : spdh_pkg::spdh_par_t'(pwdata[`SPDH_CTRL_PAR_LSB +: 2]);
		end
	end

	// mode commands only come through the serial command path, and only while it is selected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= spdh_pkg::SPDH_LOCAL;
		end else if (mode_ok) begin // [R17]
			mode_q <= spdh_pkg::spdh_mode_t'(mode_sel);
		end
	end

	// receive buffer
	always_ff @(posedge pclk) begin
		if (rx_push) begin
			rxbuf[wr_q] <= rx_data;
		end
	end

	// pointers wrap at the buffer depth, which is not a power of two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (rx_push) begin
				wr_q <= ptr_inc(wr_q);
			end
			if (rd_rx) begin
				rd_q <= ptr_inc(rd_q);
			end
			cnt_q <= cnt_q + `SPDH_RXCNT_W'(rx_push) - `SPDH_RXCNT_W'(rd_rx);
		end
	end

	// sticky errors; a new error wins over a clearing read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			perr_q <= 1'b0;
			ferr_q <= 1'b0;
		end else begin
			perr_q <= (rx_valid & rx_perr) | (perr_q & ~stat_rd);
			ferr_q <= (rx_valid & rx_ferr) | (ferr_q & ~stat_rd);
		end
	end

	// abort flag; a control-C in the same cycle as the clearing write wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_q <= 1'b0;
		end else if (ctrl_c) begin
			abort_q <= 1'b1; // [R13]
		end else if (abort_clr) begin
			abort_q <= 1'b0;
		end
	end

	// response byte held for the transmitter; control-C discards it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txhold_q   <= 8'h00;
			txhold_v_q <= 1'b0;
		end else if (ctrl_c) begin
			txhold_v_q <= 1'b0; // [R13]
		end else if (wr_tx) begin
			txhold_q   <= pwdata[7:0];
			txhold_v_q <= 1'b1;
		end else if (tx_take_hold) begin
			txhold_v_q <= 1'b0;
		end
	end

	// terminator countdown: two sends carriage return, one sends newline
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_q <= 2'd0;
		end else if (ctrl_c) begin
			term_q <= 2'd0; // [R13]
		end else if (resp_end && resp_q) begin
			term_q <= 2'd2; // [R16]
		end else if (tx_take_term) begin
			term_q <= term_q - 2'd1;
		end
	end

	// a frame already on the line when control-C lands keeps holdoff low until it has left
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_q <= 1'b0;
		end else if (ctrl_c) begin
			resp_q <= tx_busy_q;
		end else if (wr_tx) begin
			resp_q <= 1'b1; // [R9]
		end else if (resp_done) begin
			resp_q <= 1'b0;
		end
	end

	// ready is looked at only between characters, so a frame never stops halfway
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			susp_q <= 1'b0;
		end else begin
			susp_q <= en_q & tx_have & ~tx_busy_q & ~rdy_s2_q; // [R11] [R12]
		end
	end

	// transmitter: start low, lsb first, parity position, two stops high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy_q <= 1'b0;
			tx_sh_q   <= 11'h7FF;
			tx_bit_q  <= 4'h0;
			tx_cnt_q  <= '0;
		end else if (tx_start) begin
			tx_busy_q <= 1'b1;
			tx_sh_q   <= {2'b11, tx_payload, 1'b0}; // [R1] [R4] [R21]
			tx_bit_q  <= 4'h0;
			tx_cnt_q  <= bit_div;
		end else if (tx_busy_q) begin
			if (!tx_tick) begin
				tx_cnt_q <= tx_cnt_q - 1'b1;
			end else begin
				tx_cnt_q <= bit_div;
				tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
			end
			if (tx_last) begin // [R1]
				tx_busy_q <= 1'b0;
			end
		end
	end

	// the current character finishes on abort; only pending ones are discarded
	assign txd = tx_busy_q ? tx_sh_q[0] : 1'b1;

	// holdoff falls for a full buffer, a pending response or a suspended output
	assign holdoff = en_q & ~rx_full & ~resp_q & ~susp_q; // [R6] [R8] [R9] [R12]

	assign parallel_bus_en = ~en_q; // [R5]
	assign panel_keys_en   = ~en_q | (mode_q == spdh_pkg::SPDH_LOCAL); // [R18] [R19]
	assign local_key_en    = ~en_q | (mode_q != spdh_pkg::SPDH_LOCKOUT); // [R19]
	assign device_clear    = ctrl_c; // [R13]

	// apb read data
	wire [31:0] stat_w = {21'h0, ferr_q, mode_q, perr_q, abort_q, resp_q, susp_q,
	                      holdoff, tx_busy_q, rx_full, (cnt_q != '0)};
	wire [31:0] ctrl_w = {26'h0, par_q, baud_q, en_q};
	wire [31:0] rd_w   = hit_ctrl ? ctrl_w :
	                     hit_stat ? stat_w :
	                     hit_rx   ? {24'h0, rxbuf[rd_q]} :
	                     hit_tx   ? {31'h0, txhold_v_q} : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_w;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = acc & ~hit_any;
endmodule

// *** verification/spdh_serial_port_properties.sv ***
// concurrent checks on the serial port pins, bound to the port top module
`timescale 1ns/1ps
module spdh_serial_port_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        txd,
	input wire logic        holdoff,
	input wire logic        host_ready,
	input wire logic        parallel_bus_en,
	input wire logic        panel_keys_en,
	input wire logic        local_key_en,
	input wire logic        device_clear
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// lockout command written while the port is selected
	wire lock_wr = psel && penable && pwrite && paddr == 12'h010 && pwdata[3:0] == 4'hC && !parallel_bus_en;

	clear_pulse_a: assert property (device_clear |=> !device_clear)
		else $error("device clear wider than one cycle");
	lockout_keys_a: assert property (!local_key_en |-> !panel_keys_en)
		else $error("local key off while panel keys on");
	bus_excl_a: assert property (holdoff |-> !parallel_bus_en)
		else $error("both host interfaces active");
	port_off_keys_a: assert property (parallel_bus_en |-> panel_keys_en && local_key_en)
		else $error("panel keys locked while port off");
	tx_holdoff_a: assert property ($fell(txd) |-> !holdoff)
		else $error("holdoff true while a response leaves");
	low_bit_a: assert property ($fell(txd) |=> !txd [*8])
		else $error("low bit shorter than a bit period");
	high_bit_a: assert property ($rose(txd) |=> txd [*8])
		else $error("high bit shorter than a bit period");
	mode_lock_a: assert property (lock_wr |=> !local_key_en && !panel_keys_en)
		else $error("lockout command not applied");

	cover property (device_clear);
	cover property (!local_key_en);
	cover property ($fell(txd) && host_ready);
endmodule

bind spdh_serial_port spdh_serial_port_props chk_u (
	.pclk            (pclk),
	.presetn         (presetn),
	.psel            (psel),
	.penable         (penable),
	.pwrite          (pwrite),
	.paddr           (paddr),
	.pwdata          (pwdata),
	.txd             (txd),
	.holdoff         (holdoff),
	.host_ready      (host_ready),
	.parallel_bus_en (parallel_bus_en),
	.panel_keys_en   (panel_keys_en),
	.local_key_en    (local_key_en),
	.device_clear    (device_clear)
);

// *** verification/spdh_host_model.sv ***
// host computer model: sends frames on the device input, decodes device output, drives ready
`timescale 1ns/1ps
module spdh_host_model #(
	parameter int BIT_CLKS = 2083
) (
	input  wire logic pclk,
	output logic      rxd,
	input  wire logic txd,
	input  wire logic holdoff,
	output logic      host_ready
);
	logic [8:0] rxq[$];
	logic [7:0] sh;
	logic       ok;
	logic       wait_expired;

	initial begin
		rxd = 1'b1;
		host_ready = 1'b1;
		wait_expired = 1'b0;
	end

	task set_ready(input logic v);
		@(posedge pclk) host_ready <= v;
	endtask

	// with ready low the host may break through holdoff, used only for control-C
	task send_char(input logic [7:0] c);
		int k;
		k = 0;
		while (host_ready && !holdoff && k < 30000) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 30000)
			wait_expired = 1'b1;
		for (int i = 0; i < 11; i++) begin
			rxd <= (i == 0) ? 1'b0 : (i < 9) ? c[i-1] : 1'b1;
			repeat (BIT_CLKS) @(posedge pclk);
		end
	endtask

	// mid-bit sampling; both stop bits folded into one flag
	initial forever begin
		@(posedge pclk);
		if (txd === 1'b0) begin
			repeat (BIT_CLKS / 2) @(posedge pclk);
			for (int i = 0; i < 10; i++) begin
				repeat (BIT_CLKS) @(posedge pclk);
				if (i < 8)
					sh[i] = txd;
				else
					ok = (i == 8) ? txd : ok & txd;
			end
			rxq.push_back({ok, sh});
		end
	end
endmodule

// *** verification/serial_port_with_dtr_dsr_holdoff_test.sv ***
// self-checking bench for the serial port: apb master, host model, expected-character queue
`timescale 1ns/1ps
`include "spdh_regs.svh"
module serial_port_with_dtr_dsr_holdoff_test;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, rxd, txd, holdoff, host_ready, pbe, pke, lke, dclr, last_err;
	logic [7:0]  b;
	logic [7:0]  expq[$];
	int          bad_count = 0, samples_checked = 0, clr_seen = 0, n;
	int          modes[3] = '{0, 2, 1};

	always #25 pclk = ~pclk;
	always @(posedge pclk) if (dclr === 1'b1) clr_seen <= clr_seen + 1;

	spdh_serial_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
		.txd(txd), .holdoff(holdoff), .host_ready(host_ready), .parallel_bus_en(pbe), .panel_keys_en(pke),
		.local_key_en(lke), .device_clear(dclr));
	spdh_host_model host_u (.pclk(pclk), .rxd(rxd), .txd(txd), .holdoff(holdoff), .host_ready(host_ready));

	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// even parity in the top payload bit, as the port is set up
	function automatic logic [7:0] framed(input logic [7:0] c);
		return {^c[6:0], c[6:0]};
	endfunction

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			bad_count++;
			finish_test();
		end
		rd = prdata;
		last_err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask

	initial begin
		void'($urandom(32'h1987));
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk({pbe, holdoff}, 2'b10);
		apb(0, 12'h020, 0);
		chk({rd[0], last_err}, 2'b01);
		apb(1, `SPDH_CTRL_OFF, 32'h0000_001B);
		chk({pbe, holdoff}, 2'b01);
		foreach (modes[i]) begin
			apb(1, `SPDH_CMD_OFF, (modes[i] << 1) | 8);
			chk({pke, lke}, {modes[i] == 0, modes[i] != 2});
		end
		host_u.set_ready(0);
		repeat (4) @(posedge pclk);
		b = 8'($urandom) & 8'h7F;
		apb(1, `SPDH_TXDATA_OFF, {24'h0, b});
		repeat (20) @(posedge pclk);
		chk({holdoff, txd}, 2'b01);
		host_u.send_char(framed(`SPDH_CHAR_ETX));
		if (host_u.wait_expired) begin
			bad_count++;
			finish_test();
		end
		chk(clr_seen, 1);
		apb(0, `SPDH_STAT_OFF, 0);
		chk(rd[6], 1);
		apb(1, `SPDH_STAT_OFF, 32'h0000_0040);
		host_u.set_ready(1);
		repeat (200) @(posedge pclk);
		chk({holdoff, txd, 8'(host_u.rxq.size())}, 10'h300);
		// byte and end of response both wait behind a low ready; the byte must still go first
		host_u.set_ready(0);
		repeat (4) @(posedge pclk);
		b = 8'($urandom) & 8'h7F;
		apb(1, `SPDH_TXDATA_OFF, {24'h0, b});
		apb(1, `SPDH_CMD_OFF, 1);
		chk(holdoff, 0);
		chk(txd, 1);
		host_u.set_ready(1);
		expq.push_back(framed(b));
		expq.push_back(framed(`SPDH_CHAR_CR));
		expq.push_back(framed(`SPDH_CHAR_LF));
		n = 0;
		while (host_u.rxq.size() < 3 && n < 90000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 90000) begin
			bad_count++;
			finish_test();
		end
		for (int i = 0; i < 3; i++)
			chk(host_u.rxq.pop_front(), {1'b1, expq.pop_front()});
		n = 0;
		while (holdoff !== 1'b1 && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		chk(holdoff, 1);
		finish_test();
	end
endmodule
